// file: cmp_far_side.sv
`timescale 1ns/100ps
module cmp_far_side (
  // Steering from the block
  input  cmp_pkg::analog_sel_type sel,
  // Analog levels in millivolts
  input  int                      pos_mv,
  input  int                      neg_mv,
  input  int                      conv_mv [8],
  // Comparator decision
  output logic                    cmp_raw
);
  import cmp_pkg::*;
  localparam int BANDGAP_MV = 1200;
  int p_mv;
  int n_mv;
  // Input choice and decision, low when unpowered
  always_comb begin
    p_mv    = sel.pos_bandgap ? BANDGAP_MV : pos_mv;
    n_mv    = sel.neg_from_mux ? conv_mv[sel.neg_channel] : neg_mv;
    cmp_raw = !sel.power_off && (p_mv > n_mv);
  end
endmodule : cmp_far_side

// file: cmp_pkg.sv
package cmp_pkg;

  // I/O-space register offsets
  localparam logic [5:0] CTRL_STATUS_OFFSET = 6'h08;
  localparam logic [5:0] SFIO_OFFSET        = 6'h20;

  // Control and status register bit positions; the mux enable bit is in the special register
  localparam int POWER_OFF_BIT      = 7;
  localparam int BANDGAP_BIT        = 6;
  localparam int OUTPUT_STATUS_BIT  = 5;
  localparam int IRQ_FLAG_BIT       = 4;
  localparam int IRQ_ENABLE_BIT     = 3;
  localparam int CAPTURE_ROUTE_BIT  = 2;
  localparam int MODE_HI_BIT        = 1;
  localparam int MODE_LO_BIT        = 0;
  localparam int NEG_MUX_ENABLE_BIT = 3;

  // Reset values
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] SFIO_RESET        = 8'h00;

  // Synchroniser depth in cycles
  localparam int SYNC_STAGES = 2;

  // Interrupt mode encodings
  typedef enum logic [1:0] {
    MODE_TOGGLE   = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_FALLING  = 2'h2,
    MODE_RISING   = 2'h3
  } irq_mode_type;

  // Software-written control fields
  typedef struct packed {
    logic         power_off;
    logic         bandgap_select;
    logic         irq_enable;
    logic         capture_route_enable;
    irq_mode_type irq_mode;
  } cmp_ctrl_type;

  // Analog selection steering toward the front end
  typedef struct packed {
    logic       power_off;
    logic       pos_bandgap;
    logic       neg_from_mux;
    logic [2:0] neg_channel;
  } analog_sel_type;

endpackage : cmp_pkg

// file: cmp_sync.sv
`timescale 1ns/100ps
module cmp_sync (
  // Clock and control
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Data
  input  wire logic async_in,
  output logic      sync_out
);
  import cmp_pkg::*;

  logic [SYNC_STAGES-1:0] stage_reg;

  // Two-stage synchroniser; only the last stage is read outside
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage_reg <= '0;
    end else if (clk_en) begin
      stage_reg <= {stage_reg[SYNC_STAGES-2:0], async_in};
    end
  end

  assign sync_out = stage_reg[SYNC_STAGES-1];

endmodule : cmp_sync

// file: comparator_event_control.sv
`timescale 1ns/100ps
// Contract
// - Raw comparator result is synchronised; status lags by one to two cycles.
// - Mux enable with converter off picks converter input 0-7 as negative input.
// - Bandgap select routes bandgap to positive input, else the positive pin.
// - Power-off bit one removes comparator power; zero restores operation.
// - Flag sets when synchronised output shows the selected event.
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Request only while flag, enable and global interrupt enable all set.
// - Flag clears on vector acknowledge or software writing one to it.
// - Capture-route bit one drives output into timer capture; zero disconnects.
// - Comparator capture raises timer interrupt only with its mask bit set.
// - Synchronised output readable at bit 5; writes there have no effect.
// - Negative mux enable is read/write bit 3 of special register, reset zero.
// - Converter counts as on only while its enable bit is set.
module comparator_event_control (
  // Clock and control
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  // I/O register port
  input  wire logic [5:0]              io_addr,
  input  wire logic                    io_wr,
  input  wire logic                    io_rd,
  input  wire logic [7:0]              io_wdata,
  output logic      [7:0]              io_rdata,
  // Analog comparator and surroundings
  input  wire logic                    cmp_raw,
  input  wire logic                    converter_enable,
  input  wire logic [2:0]              channel_select_low,
  output cmp_pkg::analog_sel_type      analog_sel,
  // Processor interrupt
  input  wire logic                    global_irq_enable,
  input  wire logic                    irq_ack,
  output logic                         cmp_irq_req,
  // Timer capture front end
  input  wire logic                    timer_capture_irq_enable,
  output logic                         capture_in,
  output logic                         capture_irq_allowed
);
  import cmp_pkg::*;

  cmp_ctrl_type ctrl_reg;
  logic         neg_mux_enable_reg;
  logic         cmp_irq_flag_reg;
  logic         cmp_sync_out;
  logic         cmp_output_status_reg;
  logic         event_hit;
  logic         wr_ctrl;
  logic         wr_sfio;

  // Address decode for the two I/O registers
  function automatic logic addr_hit(input logic [5:0] a, input logic [5:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // Control and status word as software reads it
  function automatic logic [7:0] ctrl_word(input cmp_ctrl_type c, input logic flag, input logic status);
    ctrl_word = {c.power_off, c.bandgap_select, status, flag,
                 c.irq_enable, c.capture_route_enable, c.irq_mode};
  endfunction : ctrl_word

  assign wr_ctrl = io_wr && addr_hit(io_addr, CTRL_STATUS_OFFSET);
  assign wr_sfio = io_wr && addr_hit(io_addr, SFIO_OFFSET);

  // Comparator output synchroniser
  cmp_sync u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (cmp_raw),
    .sync_out (cmp_sync_out)
  );

  // Previous synchronised value for edge detection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmp_output_status_reg <= 1'b0;
    end else if (clk_en) begin
      cmp_output_status_reg <= cmp_sync_out;
    end
  end

  // Edge detect against the previous cycle, per mode
  always_comb begin
    case (ctrl_reg.irq_mode)
      MODE_TOGGLE:   event_hit = cmp_sync_out != cmp_output_status_reg;
      MODE_FALLING:  event_hit = !cmp_sync_out && cmp_output_status_reg;
      MODE_RISING:   event_hit = cmp_sync_out && !cmp_output_status_reg;
      MODE_RESERVED: event_hit = 1'b0;
      default:       event_hit = 1'b0;
    endcase
  end

  // Control fields; status bit 5 is not stored
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg <= cmp_ctrl_type'({CTRL_STATUS_RESET[7:6], CTRL_STATUS_RESET[3:0]});
    end else if (clk_en && wr_ctrl) begin
      ctrl_reg.power_off            <= io_wdata[POWER_OFF_BIT];
      ctrl_reg.bandgap_select       <= io_wdata[BANDGAP_BIT];
      ctrl_reg.irq_enable           <= io_wdata[IRQ_ENABLE_BIT];
      ctrl_reg.capture_route_enable <= io_wdata[CAPTURE_ROUTE_BIT];
      ctrl_reg.irq_mode             <= irq_mode_type'({io_wdata[MODE_HI_BIT], io_wdata[MODE_LO_BIT]});
    end
  end

  // Multiplexer enable in the special-function register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      neg_mux_enable_reg <= SFIO_RESET[NEG_MUX_ENABLE_BIT];
    end else if (clk_en && wr_sfio) begin
      neg_mux_enable_reg <= io_wdata[NEG_MUX_ENABLE_BIT];
    end
  end

  // Sticky flag: event wins over any clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmp_irq_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (event_hit) begin
        cmp_irq_flag_reg <= 1'b1;
      end else if (irq_ack || (wr_ctrl && io_wdata[IRQ_FLAG_BIT])) begin
        cmp_irq_flag_reg <= 1'b0;
      end
    end
  end

  // Analog steering toward the front end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      analog_sel <= '0;
    end else if (clk_en) begin
      analog_sel.power_off    <= ctrl_reg.power_off;
      analog_sel.pos_bandgap  <= ctrl_reg.bandgap_select;
      analog_sel.neg_from_mux <= neg_mux_enable_reg && !converter_enable;
      analog_sel.neg_channel  <= channel_select_low;
    end
  end

  // Comparator interrupt request toward the processor
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmp_irq_req <= 1'b0;
    end else if (clk_en) begin
      cmp_irq_req <= cmp_irq_flag_reg && ctrl_reg.irq_enable && global_irq_enable;
    end
  end

  // Route into the timer capture front end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      capture_in          <= 1'b0;
      capture_irq_allowed <= 1'b0;
    end else if (clk_en) begin
      capture_in          <= ctrl_reg.capture_route_enable && cmp_sync_out;
      capture_irq_allowed <= ctrl_reg.capture_route_enable && timer_capture_irq_enable;
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else if (clk_en) begin
      if (io_rd && addr_hit(io_addr, CTRL_STATUS_OFFSET)) begin
        io_rdata <= ctrl_word(ctrl_reg, cmp_irq_flag_reg, cmp_sync_out);
      end else if (io_rd && addr_hit(io_addr, SFIO_OFFSET)) begin
        io_rdata <= {4'h0, neg_mux_enable_reg, 3'h0};
      end else begin
        io_rdata <= 8'h00;
      end
    end
  end

  // Assertions on the interrupt path
  req_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en ##1 cmp_irq_req |-> $past(cmp_irq_flag_reg) && $past(ctrl_reg.irq_enable) && $past(global_irq_enable))
    else $error("irq request without flag and enable");

  req_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && cmp_irq_flag_reg && ctrl_reg.irq_enable && global_irq_enable |=> cmp_irq_req)
    else $error("irq request missing");

  req_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !global_irq_enable |=> !cmp_irq_req)
    else $error("irq request without global enable");

  flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && event_hit |=> cmp_irq_flag_reg)
    else $error("event did not set flag");

  flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !event_hit && !irq_ack && !(wr_ctrl && io_wdata[IRQ_FLAG_BIT]) |=> $stable(cmp_irq_flag_reg))
    else $error("flag changed without cause");

  flag_freeze_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clk_en |=> $stable(cmp_irq_flag_reg))
    else $error("flag moved while frozen");

  flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && irq_ack && !event_hit |=> !cmp_irq_flag_reg)
    else $error("ack did not clear flag");

  sw_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && wr_ctrl && io_wdata[IRQ_FLAG_BIT] && !event_hit |=> !cmp_irq_flag_reg)
    else $error("write one did not clear flag");

  // Assertions on edge selection
  reserved_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_reg.irq_mode == MODE_RESERVED |-> !event_hit)
    else $error("reserved mode raised event");

  rising_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_reg.irq_mode == MODE_RISING && event_hit |-> cmp_sync_out && !cmp_output_status_reg)
    else $error("rising mode fired on wrong edge");

  falling_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_reg.irq_mode == MODE_FALLING && event_hit |-> !cmp_sync_out && cmp_output_status_reg)
    else $error("falling mode fired on wrong edge");

  toggle_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_reg.irq_mode == MODE_TOGGLE |-> event_hit == (cmp_sync_out != cmp_output_status_reg))
    else $error("toggle mode missed a change");

  status_lag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) && $past(clk_en) && clk_en ##1 clk_en ##1 clk_en |-> cmp_output_status_reg == $past(cmp_raw, 3))
    else $error("status lag wrong");

  // Assertions on the register port
  status_ro_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && io_rd && addr_hit(io_addr, CTRL_STATUS_OFFSET) |=>
      io_rdata == ctrl_word($past(ctrl_reg), $past(cmp_irq_flag_reg), $past(cmp_sync_out)))
    else $error("status read wrong");

  sfio_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && io_rd && addr_hit(io_addr, SFIO_OFFSET) |=> io_rdata == {4'h0, $past(neg_mux_enable_reg), 3'h0})
    else $error("mux enable read wrong");

  idle_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !io_rd |=> io_rdata == 8'h00)
    else $error("read data without strobe");

  mux_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && wr_sfio |=> neg_mux_enable_reg == $past(io_wdata[NEG_MUX_ENABLE_BIT]))
    else $error("mux enable write lost");

  power_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && wr_ctrl |=> ctrl_reg.power_off == $past(io_wdata[POWER_OFF_BIT]))
    else $error("power off write lost");

  enable_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && wr_ctrl |=> ctrl_reg.irq_enable == $past(io_wdata[IRQ_ENABLE_BIT]))
    else $error("irq enable write lost");

  route_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && wr_ctrl |=> ctrl_reg.capture_route_enable == $past(io_wdata[CAPTURE_ROUTE_BIT]))
    else $error("capture route write lost");

  mode_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && wr_ctrl |=> 2'(ctrl_reg.irq_mode) == $past({io_wdata[MODE_HI_BIT], io_wdata[MODE_LO_BIT]}))
    else $error("mode write lost");

  ctrl_freeze_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clk_en |=> $stable(ctrl_reg))
    else $error("control moved while frozen");

  // Assertions on analog steering and capture
  neg_mux_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && neg_mux_enable_reg && converter_enable |=> !analog_sel.neg_from_mux)
    else $error("mux borrowed while converter on");

  neg_mux_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && neg_mux_enable_reg && !converter_enable |=>
      analog_sel.neg_from_mux && analog_sel.neg_channel == $past(channel_select_low))
    else $error("mux not borrowed while converter off");

  bandgap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> analog_sel.pos_bandgap == $past(ctrl_reg.bandgap_select))
    else $error("bandgap select not followed");

  power_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> analog_sel.power_off == $past(ctrl_reg.power_off))
    else $error("power off not followed");

  capture_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !ctrl_reg.capture_route_enable |=> !capture_in)
    else $error("capture driven while disconnected");

  capture_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && ctrl_reg.capture_route_enable |=> capture_in == $past(cmp_sync_out))
    else $error("capture not following output");

  cap_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> capture_irq_allowed == ($past(ctrl_reg.capture_route_enable) && $past(timer_capture_irq_enable)))
    else $error("capture irq without mask");

  // Main scenarios
  toggle_c:  cover property (@(posedge sys_clk) ctrl_reg.irq_mode == MODE_TOGGLE && event_hit);
  falling_c: cover property (@(posedge sys_clk) ctrl_reg.irq_mode == MODE_FALLING && event_hit);
  req_c:     cover property (@(posedge sys_clk) cmp_irq_req);
  capture_c: cover property (@(posedge sys_clk) capture_in);
  ack_c:     cover property (@(posedge sys_clk) irq_ack && cmp_irq_flag_reg);

endmodule : comparator_event_control

// file: comparator_event_control_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin num_errors++; $display("Error %s expected %h seen %h", nm, e, a); end end
module comparator_event_control_test;
  import cmp_pkg::*;
  logic           sys_clk = 0, rst_n = 0, io_wr = 0, io_rd = 0, cmp_raw;
  logic           conv_en = 0, gie = 0, ack = 0, tmask = 0, ce = 1;
  logic [5:0]     io_addr = 6'h00;
  logic [7:0]     io_wdata = 8'h00, io_rdata, d;
  logic [2:0]     chan = 3'h0;
  logic           irq_req, cap_in, cap_ok;
  analog_sel_type sel;
  int             pos_mv = 0, neg_mv = 500, conv_mv [8] = '{default: 0};
  int             num_errors = 0, total_checks = 0;

  // Clock
  always #5 sys_clk = ~sys_clk;

  comparator_event_control DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(ce), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .cmp_raw(cmp_raw),
    .converter_enable(conv_en), .channel_select_low(chan), .analog_sel(sel), .global_irq_enable(gie),
    .irq_ack(ack), .cmp_irq_req(irq_req), .timer_capture_irq_enable(tmask), .capture_in(cap_in),
    .capture_irq_allowed(cap_ok));

  cmp_far_side far (.sel(sel), .pos_mv(pos_mv), .neg_mv(neg_mv), .conv_mv(conv_mv), .cmp_raw(cmp_raw));

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // One-cycle register write
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    io_addr = a;
    io_wdata = v;
    io_wr = 1;
    @(negedge sys_clk);
    io_wr = 0;
  endtask : wr

  // Read, data registered one cycle later
  task automatic rd(input logic [5:0] a);
    @(negedge sys_clk);
    io_addr = a;
    io_rd = 1;
    @(negedge sys_clk);
    io_rd = 0;
    d = io_rdata;
  endtask : rd

  // Rise then fall under one mode, enable kept clear
  task automatic mode_run(input logic [1:0] m, input logic er, input logic ef);
    wr(6'h08, {6'b000100, m});
    pos_mv = 900;
    cyc(5);
    rd(6'h08);
    `CHK("flag rise", er, d[IRQ_FLAG_BIT])
    `CHK("status", 1'b1, d[OUTPUT_STATUS_BIT])
    wr(6'h08, {6'b000100, m});
    pos_mv = 0;
    cyc(5);
    rd(6'h08);
    `CHK("flag fall", ef, d[IRQ_FLAG_BIT])
  endtask : mode_run

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end

  initial begin
    cyc(3);
    rst_n = 1;
    rd(6'h08);
    `CHK("ctrl reset", 8'h00, d)
    rd(6'h20);
    `CHK("sfio reset", 8'h00, d)
    rd(6'h15);
    `CHK("unmapped", 8'h00, d)
    wr(6'h20, 8'hFF);
    rd(6'h20);
    `CHK("sfio rw", 8'h08, d)
    conv_mv[5] = 800;
    chan = 3'h5;
    cyc(2);
    `CHK("neg mux", 6'h0D, sel)
    conv_en = 1;
    cyc(2);
    `CHK("conv on", 1'b0, sel.neg_from_mux)
    conv_en = 0;
    wr(6'h08, 8'hE0);
    cyc(2);
    `CHK("sel off", 6'h3D, sel)
    rd(6'h08);
    `CHK("ro bit", 8'hC0, d)
    wr(6'h08, 8'h40);
    cyc(5);
    rd(6'h08);
    `CHK("bandgap", 8'h70, d)
    wr(6'h08, 8'h10);
    wr(6'h20, 8'h00);
    cyc(5);
    $display("test registers done");
    mode_run(2'h0, 1'b1, 1'b1);
    mode_run(2'h1, 1'b0, 1'b0);
    mode_run(2'h2, 1'b0, 1'b1);
    mode_run(2'h3, 1'b1, 1'b0);
    $display("test modes done");
    wr(6'h08, 8'h13);
    pos_mv = 900;
    cyc(5);
    `CHK("req masked", 1'b0, irq_req)
    wr(6'h08, 8'h0B);
    gie = 1;
    cyc(2);
    `CHK("req on", 1'b1, irq_req)
    gie = 0;
    cyc(2);
    `CHK("req gie", 1'b0, irq_req)
    gie = 1;
    ack = 1;
    cyc(1);
    ack = 0;
    cyc(2);
    `CHK("req ack", 1'b0, irq_req)
    rd(6'h08);
    `CHK("flag ack", 1'b0, d[IRQ_FLAG_BIT])
    wr(6'h08, 8'h00);
    $display("test irq done");
    pos_mv = 0;
    wr(6'h08, 8'h04);
    tmask = 1;
    cyc(5);
    pos_mv = 900;
    cyc(1);
    `CHK("cap lag", 1'b0, cap_in)
    cyc(4);
    `CHK("cap in", 1'b1, cap_in)
    `CHK("cap irq", 1'b1, cap_ok)
    tmask = 0;
    cyc(2);
    `CHK("cap mask", 1'b0, cap_ok)
    wr(6'h08, 8'h00);
    cyc(2);
    `CHK("cap off", 1'b0, cap_in)
    $display("test capture done");
    ce = 0;
    wr(6'h08, 8'h40);
    ce = 1;
    rd(6'h08);
    `CHK("freeze", 1'b0, d[BANDGAP_BIT])
    $display("test freeze done");
    print_verdict();
  end
endmodule : comparator_event_control_test
